// file: src/serial_eeprom_write_guard.sv
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_write_guard #(
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLE_CYCLES
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Two-wire link
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Board pins
	input wire logic [eeprom_pkg::STRAP_W-1:0] bus_select_straps,
	input wire logic write_protect
);

	localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);
	localparam int SYNC_W = eeprom_pkg::STRAP_W + 3;

	// ==========================================================
	// Pin synchronisers; line pins pass inverted, so reset reads idle high
	logic [SYNC_W-1:0] pins_s;
	logic scl_s, sda_s, wp_s;
	logic [eeprom_pkg::STRAP_W-1:0] straps_s;
	logic scl_q, sda_q;

	pin_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.pins({bus_select_straps, write_protect, ~sda_i, ~scl}),
		.synced(pins_s)
	);

	assign scl_s = !pins_s[0];
	assign sda_s = !pins_s[1];
	assign wp_s = pins_s[2];
	assign straps_s = pins_s[SYNC_W-1:3];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	logic scl_rise, scl_fall, start_cond, stop_cond;
	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	// Line changes while the clock stays high frame a transfer
	assign start_cond = scl_s && scl_q && sda_q && !sda_s;
	assign stop_cond = scl_s && scl_q && !sda_q && sda_s;

	// ==========================================================
	// Shared state
	eeprom_pkg::link_state_e state;
	logic [3:0] bit_cnt;
	logic [1:0] byte_idx;
	logic [7:0] rx_sh, tx_sh, ptr;
	logic rw, host_ack;
	logic perm_lock, rev_lock;
	logic [BUSY_W-1:0] busy_cnt;
	logic busy, pending;
	logic [7:0] mem [eeprom_pkg::MEM_DEPTH];
	logic write_allowed;

	assign busy = (busy_cnt != '0);

	protect_decode u_protect (
		.hw_protect(wp_s),
		.perm_lock(perm_lock),
		.rev_lock(rev_lock),
		.addr(ptr),
		.write_allowed(write_allowed)
	);

	logic rx_done, dev_match, ack_now, data_byte, mem_we, refused;
	assign rx_done = scl_fall && (state == eeprom_pkg::ST_RX)
		&& (bit_cnt == eeprom_pkg::BITS_PER_WORD);
	// Busy device ignores its address until programming ends
	assign dev_match = (rx_sh[7:1] == {eeprom_pkg::DEVICE_CODE, straps_s})
		&& !busy;
	assign data_byte = (byte_idx == 2'd2);
	assign ack_now = rx_done && ((byte_idx != 2'd0) || dev_match);
	assign mem_we = rx_done && data_byte && write_allowed;
	assign refused = rx_done && data_byte && !write_allowed;

	// ==========================================================
	// Link state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= eeprom_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			byte_idx <= 2'd0;
			rx_sh <= 8'h00;
			tx_sh <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			host_ack <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start_cond) begin
			state <= eeprom_pkg::ST_RX;
			bit_cnt <= 4'h0;
			byte_idx <= 2'd0;
			sda_oe <= 1'b0;
		end else if (stop_cond) begin
			state <= eeprom_pkg::ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				eeprom_pkg::ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				eeprom_pkg::ST_RX: begin
					if (scl_rise) begin
						rx_sh <= {rx_sh[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (rx_done) begin
						bit_cnt <= 4'h0;
						if (ack_now) begin
							state <= eeprom_pkg::ST_ACK;
							sda_oe <= 1'b1;
							if (byte_idx == 2'd0) begin
								rw <= rx_sh[0];
							end
							if (byte_idx == 2'd1) begin
								ptr <= rx_sh;
							end
							if (data_byte) begin
								// Page writes wrap inside the page
								ptr[3:0] <= ptr[3:0] + 4'h1;
							end else begin
								byte_idx <= byte_idx + 2'd1;
							end
						end else begin
							state <= eeprom_pkg::ST_IDLE;
						end
					end
				end
				eeprom_pkg::ST_ACK: begin
					if (scl_fall) begin
						if (rw) begin
							state <= eeprom_pkg::ST_TX;
							sda_oe <= ~mem[ptr][7];
							tx_sh <= {mem[ptr][6:0], 1'b0};
							ptr <= ptr + 8'h01;
							bit_cnt <= 4'h1;
						end else begin
							state <= eeprom_pkg::ST_RX;
							sda_oe <= 1'b0;
						end
					end
				end
				eeprom_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == eeprom_pkg::BITS_PER_WORD) begin
							state <= eeprom_pkg::ST_TXACK;
							sda_oe <= 1'b0;
							bit_cnt <= 4'h0;
						end else begin
							sda_oe <= ~tx_sh[7];
							tx_sh <= {tx_sh[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				eeprom_pkg::ST_TXACK: begin
					if (scl_rise) begin
						host_ack <= !sda_s;
					end else if (scl_fall) begin
						if (host_ack) begin
							state <= eeprom_pkg::ST_TX;
							sda_oe <= ~mem[ptr][7];
							tx_sh <= {mem[ptr][6:0], 1'b0};
							ptr <= ptr + 8'h01;
							bit_cnt <= 4'h1;
						end else begin
							state <= eeprom_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state <= eeprom_pkg::ST_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// Open drain: the only level ever driven is low
	assign sda_o = 1'b0;

	// ==========================================================
	// Array
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < eeprom_pkg::MEM_DEPTH; i++) begin
				mem[i] <= eeprom_pkg::ERASED_BYTE;
			end
		end else if (mem_we) begin
			mem[ptr] <= rx_sh;
		end
	end

	// ==========================================================
	// Programming cycle, started by the stop after accepted data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending <= 1'b0;
			busy_cnt <= '0;
		end else begin
			if (stop_cond && (pending || mem_we)) begin
				busy_cnt <= BUSY_W'(WRITE_CYCLES);
				pending <= 1'b0;
			end else begin
				if (mem_we) begin
					pending <= 1'b1;
				end else if (start_cond && !busy) begin
					pending <= pending;
				end
				if (busy) begin
					busy_cnt <= busy_cnt - BUSY_W'(1);
				end
			end
		end
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states
	logic dp_write;
	logic [7:0] dp_addr;
	logic ap_valid;
	assign ap_valid = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			dp_write <= ap_valid && hwrite;
			dp_addr <= haddr[eeprom_pkg::REG_ADDR_W-1:0];
		end
	end

	logic wr_ctrl, set_perm, set_rev, clr_rev, clr_refused;
	assign wr_ctrl = dp_write && (dp_addr == eeprom_pkg::REG_CTRL);
	assign set_perm = wr_ctrl && hwdata[eeprom_pkg::CTRL_SET_PERM];
	assign set_rev = wr_ctrl && hwdata[eeprom_pkg::CTRL_SET_REV];
	assign clr_rev = wr_ctrl && hwdata[eeprom_pkg::CTRL_CLR_REV];
	assign clr_refused = wr_ctrl && hwdata[eeprom_pkg::CTRL_CLR_REFUSED];

	// Protection locks; setting beats clearing in the same write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			perm_lock <= 1'b0;
			rev_lock <= 1'b0;
		end else begin
			if (set_perm) begin
				perm_lock <= 1'b1;
			end
			if (set_rev) begin
				rev_lock <= 1'b1;
			end else if (clr_rev) begin
				rev_lock <= 1'b0;
			end
		end
	end

	// Refused-write count; a refusal in the clearing cycle is kept
	logic [eeprom_pkg::REFUSED_W-1:0] refused_cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refused_cnt <= '0;
		end else if (clr_refused) begin
			refused_cnt <= refused ? 16'h0001 : 16'h0000;
		end else if (refused && (refused_cnt != 16'hFFFF)) begin
			refused_cnt <= refused_cnt + 16'h0001;
		end
	end

	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[eeprom_pkg::STAT_PERM] = perm_lock;
		status_word[eeprom_pkg::STAT_REV] = rev_lock;
		status_word[eeprom_pkg::STAT_WP] = wp_s;
		status_word[eeprom_pkg::STAT_BUSY] = busy;
		status_word[eeprom_pkg::STAT_STRAP_LSB +: eeprom_pkg::STRAP_W] =
			straps_s;
		status_word[eeprom_pkg::STAT_STATE_LSB +: 3] = state;
	end

	// Read data captured in the address phase, stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			unique case (haddr[eeprom_pkg::REG_ADDR_W-1:0])
				eeprom_pkg::REG_STATUS: hrdata <= status_word;
				eeprom_pkg::REG_REFUSED: hrdata <= {16'h0000, refused_cnt};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule
`default_nettype wire

// file: src/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;

	// ==========================================================
	// Array geometry
	localparam int ADDR_W = 8;
	localparam int MEM_DEPTH = 256;
	localparam int DATA_W = 8;
	localparam int PAGE_BITS = 4;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] LOWER_HALF_LAST = 8'h7F;

	// ==========================================================
	// Serial addressing
	localparam int STRAP_W = 3;
	localparam logic [3:0] DEVICE_CODE = 4'hA;
	localparam logic [3:0] BITS_PER_WORD = 4'h8;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int WRITE_CYCLE_MS = 5;
	localparam int WRITE_CYCLE_CYCLES =
		(WRITE_CYCLE_MS * 1000000) / CLK_PERIOD_NS;

	// ==========================================================
	// Register map (byte addresses)
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_REFUSED = 8'h08;

	// Control bits, write one to act
	localparam int CTRL_SET_PERM = 0;
	localparam int CTRL_SET_REV = 1;
	localparam int CTRL_CLR_REV = 2;
	localparam int CTRL_CLR_REFUSED = 3;

	// Status fields
	localparam int STAT_PERM = 0;
	localparam int STAT_REV = 1;
	localparam int STAT_WP = 2;
	localparam int STAT_BUSY = 3;
	localparam int STAT_STRAP_LSB = 8;
	localparam int STAT_STATE_LSB = 12;

	localparam int REFUSED_W = 16;

	// ==========================================================
	// Link states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_TXACK = 3'b100
	} link_state_e;

endpackage
`default_nettype wire

// file: src/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins in, synchronised out
	input wire logic [W-1:0] pins,
	output logic [W-1:0] synced
);

	logic [W-1:0] stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			synced <= '0;
		end else begin
			stage1 <= pins;
			synced <= stage1;
		end
	end

endmodule
`default_nettype wire

// file: src/protect_decode.sv
`timescale 1ns/10ps
`default_nettype none
module protect_decode (
	// Protection state
	input wire logic hw_protect,
	input wire logic perm_lock,
	input wire logic rev_lock,
	// Target location
	input wire logic [7:0] addr,
	output logic write_allowed
);

	logic in_lower;

	assign in_lower = (addr <= eeprom_pkg::LOWER_HALF_LAST);

	always_comb begin
		if (hw_protect) begin
			write_allowed = 1'b0;
		end else if ((perm_lock || rev_lock) && in_lower) begin
			write_allowed = 1'b0;
		end else begin
			write_allowed = 1'b1;
		end
	end

endmodule
`default_nettype wire

// file: src/unused_placeholder_removed.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: tb/guard_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module guard_checker (
	// Bus side
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Link and pins
	input wire logic scl,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic [eeprom_pkg::STRAP_W-1:0] bus_select_straps,
	input wire logic write_protect
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_st;
	logic rd_q;
	logic perm_seen;
	assign rd_st = hsel && hready && htrans[1] && !hwrite &&
		haddr[7:0] == eeprom_pkg::REG_STATUS;
	// ==========================================================
	// Permanent lock seen by software, must never fall back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'h0;
			perm_seen <= 1'h0;
		end else begin
			rd_q <= rd_st;
			perm_seen <= perm_seen | (rd_q & hrdata[0]);
		end
	end
	sequence wp_hi_rd; write_protect [*4] ##0 rd_st; endsequence
	sequence wp_lo_rd; !write_protect [*4] ##0 rd_st; endsequence
	sequence strap_rd; $stable(bus_select_straps) [*4] ##0 rd_st; endsequence
	sequence oe_pulse; sda_oe [*6]; endsequence
	AST_OPEN_DRAIN: assert property (sda_o == 1'h0)
		else $error("data line driven high");
	AST_OE_HOLD: assert property (scl && $past(scl) |-> $stable(sda_oe))
		else $error("data output moved while clock high");
	AST_ACK_LEN: assert property ($rose(sda_oe) |-> oe_pulse)
		else $error("low pull shorter than a clock period");
	AST_WP_SET: assert property (wp_hi_rd |=> hrdata[2])
		else $error("protect pin not reflected");
	AST_WP_CLR: assert property (wp_lo_rd |=> !hrdata[2])
		else $error("protect pin stuck");
	AST_STRAPS: assert property (strap_rd |=>
		hrdata[10:8] == $past(bus_select_straps)) else $error("straps wrong");
	AST_PERM_STICKY: assert property (rd_st && perm_seen |=> hrdata[0])
		else $error("permanent lock cleared");
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus response not okay");
endmodule
`default_nettype wire

// file: tb/twi_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module twi_ctrl_model (
	// Clock
	input wire logic hclk,
	// Two-wire link
	output logic scl,
	output logic pull_low,
	input wire logic sda
);
	// Clock parks high between frames
	initial begin
		scl = 1'h1;
		pull_low = 1'h0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Data set mid low phase, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'h0;
		tick(2);
		pull_low <= !b;
		tick(2);
		scl <= 1'h1;
		tick(2);
		r = sda;
		tick(2);
	endtask
	// Start is cond(0,1), stop is cond(1,0)
	task automatic cond(input logic a, input logic b);
		scl <= 1'h0;
		tick(2);
		pull_low <= a;
		tick(2);
		scl <= 1'h1;
		tick(4);
		pull_low <= b;
		tick(4);
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'h1, r);
		ack = !r;
	endtask
	task automatic recv(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
		bit_io(!more, r);
	endtask
endmodule
`default_nettype wire

// file: tb/serial_eeprom_write_guard_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_write_guard_tb_top;
	localparam int WC = 200;
	logic hclk = 1'h0;
	logic hresetn, hsel, hwrite, hreadyout, hresp, scl, pull_low, sda_o;
	logic sda_oe, wp;
	logic [1:0] htrans;
	logic [2:0] straps;
	logic [31:0] haddr, hwdata, hrdata, got;
	logic [31:0] seed = 32'h2816B91C;
	logic [31:0] exp_q[$];
	string nm_q[$];
	logic [7:0] mem[256];
	logic [7:0] r;
	logic k;
	int n_fail = 0;
	int samples_checked = 0;
	int ref_cnt = 0;
	event got_e;
	wire logic sda;
	// Pull-up wins when nobody pulls
	assign sda = (pull_low | sda_oe) ? 1'h0 : 1'h1;
	always #20 hclk = ~hclk;
	serial_eeprom_write_guard #(.WRITE_CYCLES(WC)) uut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.bus_select_straps(straps), .write_protect(wp));
	twi_ctrl_model m (.hclk(hclk), .scl(scl), .pull_low(pull_low), .sda(sda));
	function automatic logic [7:0] rnd8();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(string nm, logic [31:0] g, logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, e, g);
		end
	endtask
	task automatic note(string nm, logic [31:0] e, logic [31:0] g);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		got = g;
		-> got_e;
	endtask
	always @(got_e) check(nm_q.pop_front(), got, exp_q.pop_front());
	task automatic tally_and_finish();
		// Let the last queued compare run first
		@(posedge hclk);
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'h1) begin
			n++;
			if (n > 64) begin
				n_fail++;
				tally_and_finish();
			end
			@(posedge hclk);
		end
	endtask
	task automatic ahb(logic w, logic [7:0] a, logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e);
		logic [31:0] v;
		ahb(1'h0, a, 32'h0, v);
		note(nm, e, v);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] v;
		ahb(1'h1, a, d, v);
	endtask
	task automatic dev(logic rw);
		m.cond(1'h0, 1'h1);
		m.send({eeprom_pkg::DEVICE_CODE, straps, rw}, k);
	endtask
	// Protected write must leave the device free at once
	task automatic wr_rd(logic [7:0] a, logic prot);
		logic [7:0] d;
		d = rnd8();
		// A byte equal to the old one could not show a leaked write
		if (d == mem[a]) d = ~d;
		dev(1'h0);
		note("adr ack", 32'h1, 32'(k));
		m.send(a, k);
		m.send(d, k);
		note("data ack", 32'h1, 32'(k));
		m.cond(1'h1, 1'h0);
		dev(1'h0);
		note("busy probe", 32'(prot), 32'(k));
		m.cond(1'h1, 1'h0);
		if (!prot) mem[a] = d;
		if (prot) ref_cnt++;
		if (!prot) m.tick(WC);
		dev(1'h0);
		m.send(a, k);
		dev(1'h1);
		m.recv(1'h0, d);
		m.cond(1'h1, 1'h0);
		note("byte", 32'(mem[a]), 32'(d));
	endtask
	initial begin
		foreach (mem[i]) mem[i] = eeprom_pkg::ERASED_BYTE;
		hresetn = 1'h0;
		hsel = 1'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		wp = 1'h0;
		r = rnd8();
		straps = r[2:0];
		repeat (12) @(posedge hclk);
		hresetn <= 1'h1;
		m.tick(4);
		rd_chk("status", 8'h04, {21'h0, straps, 8'h0});
		rd_chk("refused", 8'h08, 32'h0);
		rd_chk("ctrl", 8'h00, 32'h0);
		rd_chk("unmapped", 8'h0C, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			m.cond(1'h0, 1'h1);
			m.send({eeprom_pkg::DEVICE_CODE, 3'(i), 1'h0}, k);
			note("select", 32'(3'(i) == straps), 32'(k));
			m.cond(1'h1, 1'h0);
		end
		$display("test select done");
		wr_rd(8'h10, 1'h0);
		wr_rd(8'h90, 1'h0);
		wp <= 1'h1;
		m.tick(4);
		rd_chk("status wp", 8'h04, {21'h0, straps, 8'h4});
		wr_rd(8'h10, 1'h1);
		wr_rd(8'hA0, 1'h1);
		rd_chk("refused", 8'h08, 32'(ref_cnt));
		wr(8'h00, 32'h8);
		rd_chk("refused clr", 8'h08, 32'h0);
		wp <= 1'h0;
		$display("test pin done");
		wr(8'h00, 32'h2);
		wr_rd(8'h7F, 1'h1);
		wr_rd(8'h80, 1'h0);
		wr(8'h00, 32'h4);
		wr_rd(8'h7F, 1'h0);
		wr(8'h00, 32'h1);
		wr_rd(8'h00, 1'h1);
		wr_rd(8'hFF, 1'h0);
		wr(8'h00, 32'h4);
		rd_chk("status perm", 8'h04, {21'h0, straps, 8'h1});
		wr_rd(8'h01, 1'h1);
		wr(8'h00, 32'h6);
		rd_chk("status both", 8'h04, {21'h0, straps, 8'h3});
		$display("test locks done");
		tally_and_finish();
	end
endmodule
bind serial_eeprom_write_guard guard_checker chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .scl(scl), .sda_o(sda_o),
	.sda_oe(sda_oe), .bus_select_straps(bus_select_straps),
	.write_protect(write_protect));
`default_nettype wire
